// *** aux_pin_function_select.sv ***
// per-pin function selector for the auxiliary pin bank, with APB config registers
// assumes serial engine and usb state on clk_sys; clock sources come from the clock generator
// Behaviour
// - general options on pins 0-6, 8, 9 only
// - driver enable spans pre-start bit to stop end
// - power enable low when configured, high suspended
// - tx led pulses low while transmitting
// - rx led pulses low while receiving
// - combined led pulses on either direction
// - suspend indicator low throughout usb suspend
// - clock outputs on pins 0,5,6,8,9, stop suspended
// - bit-bang io only on pins 5,6,8,9
// - reset default pulled-up, pin 7 pulled down
`timescale 1ns/1ps

module aux_pin_function_select #(
    parameter int LED_STRETCH = aux_pin_pkg::LED_STRETCH_CYC
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   tx_start_pending,
    input  wire logic                   tx_frame_active,
    input  wire logic                   rx_frame_active,
    input  wire logic                   usb_configured,
    input  wire logic                   usb_suspend,
    input  wire logic                   clk_fast_src,
    input  wire logic                   clk_mid_src,
    input  wire logic                   clk_slow_src,
    input  wire logic [9:0]             pin_in,
    output aux_pin_pkg::pin_drive_t [9:0] aux_pin_bank
);

    localparam int NP = aux_pin_pkg::NUM_PINS;
    localparam int CW = $clog2(LED_STRETCH + 1);

    // refuse a stretch the counter cannot serve
    if (LED_STRETCH < 1) begin : g_bad_stretch
        $error("LED_STRETCH must be at least one cycle");
    end

    logic [31:0]   cfg_lo_reg;
    logic [7:0]    cfg_hi_reg;
    logic [9:0]    bb_out_reg;
    logic [9:0]    bb_dir_reg;
    logic [31:0]   prdata_reg;
    logic          pslverr_reg;
    logic [9:0]    sync1_reg;
    logic [9:0]    sync2_reg;
    logic [9:0]    sync3_reg;
    logic [9:0]    pin_level_reg;
    logic [CW-1:0] tx_cnt_reg;
    logic [CW-1:0] rx_cnt_reg;
    logic          drv_en_reg;
    logic          pwr_n_reg;
    logic          sleep_n_reg;
    logic          tx_led_n_reg;
    logic          rx_led_n_reg;
    logic          both_led_n_reg;

    // apb decode
    wire           setup_phase = psel & ~penable;
    wire           wr_access   = psel & penable & pwrite;
    wire           hit_cfg_lo  = (paddr == aux_pin_pkg::OFS_CFG_LO);
    wire           hit_cfg_hi  = (paddr == aux_pin_pkg::OFS_CFG_HI);
    wire           hit_bb_out  = (paddr == aux_pin_pkg::OFS_BB_OUT);
    wire           hit_bb_dir  = (paddr == aux_pin_pkg::OFS_BB_DIR);
    wire           hit_pin_in  = (paddr == aux_pin_pkg::OFS_PIN_IN);
    wire           hit_status  = (paddr == aux_pin_pkg::OFS_STATUS);
    wire           hit_any     = hit_cfg_lo | hit_cfg_hi | hit_bb_out | hit_bb_dir
                                 | hit_pin_in | hit_status;
    wire [31:0]    cfg_all     = {24'h000000, cfg_hi_reg};
    wire [39:0]    cfg_flat    = {cfg_all[7:0], cfg_lo_reg};
    wire [31:0]    status_word = {27'h0000000, drv_en_reg, ~rx_led_n_reg, ~tx_led_n_reg,
                                  usb_suspend, usb_configured};
    wire [31:0]    rd_mux      = hit_cfg_lo ? cfg_lo_reg :
                                 hit_cfg_hi ? cfg_all :
                                 hit_bb_out ? {22'h000000, bb_out_reg} :
                                 hit_bb_dir ? {22'h000000, bb_dir_reg} :
                                 hit_pin_in ? {22'h000000, pin_level_reg} :
                                 hit_status ? status_word : 32'h00000000;

    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg & psel & penable;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_lo_reg  <= aux_pin_pkg::CFG_LO_RESET;
            cfg_hi_reg  <= aux_pin_pkg::CFG_HI_RESET;
            bb_out_reg  <= 10'h000;
            bb_dir_reg  <= 10'h000;
        end else if (wr_access) begin
            if (hit_cfg_lo) cfg_lo_reg <= pwdata;
            if (hit_cfg_hi) cfg_hi_reg <= pwdata[7:0];
            if (hit_bb_out) bb_out_reg <= pwdata[9:0];
            if (hit_bb_dir) bb_dir_reg <= pwdata[9:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (setup_phase) begin
            prdata_reg  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_reg <= ~hit_any;
        end
    end

    // pin input synchroniser, level cleared while stages two and three differ, set once both are high
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1_reg     <= 10'h000;
            sync2_reg     <= 10'h000;
            sync3_reg     <= 10'h000;
            pin_level_reg <= 10'h000;
        end else begin
            sync1_reg     <= pin_in;
            sync2_reg     <= sync1_reg;
            sync3_reg     <= sync2_reg;
            pin_level_reg <= (pin_level_reg & ~(sync2_reg ^ sync3_reg))
                             | (sync2_reg & ~(sync2_reg ^ sync3_reg));
        end
    end

    // activity stretch counters
    wire [CW-1:0] stretch_load = CW'(LED_STRETCH);
    wire [CW-1:0] tx_cnt_next  = tx_frame_active ? stretch_load :
                                 (tx_cnt_reg != '0) ? tx_cnt_reg - 1'b1 : tx_cnt_reg;
    wire [CW-1:0] rx_cnt_next  = rx_frame_active ? stretch_load :
                                 (rx_cnt_reg != '0) ? rx_cnt_reg - 1'b1 : rx_cnt_reg;
    wire          tx_act       = tx_frame_active | (tx_cnt_reg != '0);
    wire          rx_act       = rx_frame_active | (rx_cnt_reg != '0);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_cnt_reg     <= '0;
            rx_cnt_reg     <= '0;
            drv_en_reg     <= 1'b0;
            pwr_n_reg      <= 1'b1;
            sleep_n_reg    <= 1'b1;
            tx_led_n_reg   <= 1'b1;
            rx_led_n_reg   <= 1'b1;
            both_led_n_reg <= 1'b1;
        end else begin
            tx_cnt_reg     <= tx_cnt_next;
            rx_cnt_reg     <= rx_cnt_next;
            drv_en_reg     <= tx_start_pending | tx_frame_active;
            pwr_n_reg      <= ~(usb_configured & ~usb_suspend);
            sleep_n_reg    <= ~usb_suspend;
            tx_led_n_reg   <= ~tx_act;
            rx_led_n_reg   <= ~rx_act;
            both_led_n_reg <= ~(tx_act | rx_act);
        end
    end

    // clocks gated off during suspend
    wire clk_run = ~usb_suspend;
    wire fast_q  = clk_fast_src & clk_run;
    wire mid_q   = clk_mid_src & clk_run;
    wire slow_q  = clk_slow_src & clk_run;

    genvar i;
    generate
        for (i = 0; i < NP; i++) begin : g_pin
            aux_pin_pkg::pin_option_t opt;
            logic                     gen_ok;
            logic                     clk_ok;
            logic                     bb_ok;
            assign opt    = aux_pin_pkg::pin_option_t'(cfg_flat[i*4 +: 4]);
            assign gen_ok = aux_pin_pkg::GENERAL_PINS[i];
            assign clk_ok = aux_pin_pkg::CLOCK_PINS[i];
            assign bb_ok  = aux_pin_pkg::BITBANG_PINS[i];

            always_comb begin
                aux_pin_bank[i] = '{out: 1'b0, oe: 1'b0, pull_up: 1'b1, pull_down: 1'b0};
                case (opt)
                    aux_pin_pkg::OPT_LINE_DRIVER_EN: begin
                        if (gen_ok) aux_pin_bank[i] = '{drv_en_reg, 1'b1, 1'b0, 1'b0};
                    end
                    aux_pin_pkg::OPT_POWER_ENABLE_N: begin
                        if (gen_ok) aux_pin_bank[i] = '{pwr_n_reg, 1'b1, 1'b0, 1'b0};
                    end
                    aux_pin_pkg::OPT_TX_LED_N: begin
                        if (gen_ok) aux_pin_bank[i] = '{tx_led_n_reg, 1'b1, 1'b0, 1'b0};
                    end
                    aux_pin_pkg::OPT_RX_LED_N: begin
                        if (gen_ok) aux_pin_bank[i] = '{rx_led_n_reg, 1'b1, 1'b0, 1'b0};
                    end
                    aux_pin_pkg::OPT_COMBINED_LED_N: begin
                        if (gen_ok) aux_pin_bank[i] = '{both_led_n_reg, 1'b1, 1'b0, 1'b0};
                    end
                    aux_pin_pkg::OPT_SUSPEND_N: begin
                        if (gen_ok) aux_pin_bank[i] = '{sleep_n_reg, 1'b1, 1'b0, 1'b0};
                    end
                    aux_pin_pkg::OPT_CLOCK_FAST: begin
                        if (clk_ok) aux_pin_bank[i] = '{fast_q, 1'b1, 1'b0, 1'b0};
                    end
                    aux_pin_pkg::OPT_CLOCK_MID: begin
                        if (clk_ok) aux_pin_bank[i] = '{mid_q, 1'b1, 1'b0, 1'b0};
                    end
                    aux_pin_pkg::OPT_CLOCK_SLOW: begin
                        if (clk_ok) aux_pin_bank[i] = '{slow_q, 1'b1, 1'b0, 1'b0};
                    end
                    aux_pin_pkg::OPT_DRIVE_HIGH: begin
                        if (clk_ok) aux_pin_bank[i] = '{1'b1, 1'b1, 1'b0, 1'b0};
                    end
                    aux_pin_pkg::OPT_DRIVE_LOW: begin
                        if (gen_ok) aux_pin_bank[i] = '{1'b0, 1'b1, 1'b0, 1'b0};
                    end
                    aux_pin_pkg::OPT_BITBANG: begin
                        if (bb_ok) begin
                            aux_pin_bank[i] = '{bb_out_reg[i], bb_dir_reg[i],
                                                ~bb_dir_reg[i], 1'b0};
                        end
                    end
                    aux_pin_pkg::OPT_INPUT_PULLED_LOW: begin
                        if (!gen_ok) aux_pin_bank[i] = '{1'b0, 1'b0, 1'b0, 1'b1};
                    end
                    default: begin
                        aux_pin_bank[i] = '{1'b0, 1'b0, 1'b1, 1'b0};
                    end
                endcase
            end
        end
    endgenerate

endmodule // aux_pin_function_select

// *** aux_pin_pkg.sv ***
// constants, option codes and pin carrier type for the auxiliary pin selector
// assumes a 40 MHz system clock and a 32-bit APB register window
package aux_pin_pkg;

    localparam int          NUM_PINS        = 10;
    localparam int          CLK_PERIOD_NS   = 25;
    localparam int          LED_MIN_TIME_US = 50000;
    localparam int          LED_STRETCH_CYC = (LED_MIN_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0]  OFS_CFG_LO      = 8'h00;
    localparam logic [7:0]  OFS_CFG_HI      = 8'h04;
    localparam logic [7:0]  OFS_BB_OUT      = 8'h08;
    localparam logic [7:0]  OFS_BB_DIR      = 8'h0c;
    localparam logic [7:0]  OFS_PIN_IN      = 8'h10;
    localparam logic [7:0]  OFS_STATUS      = 8'h14;

    // status field positions
    localparam int          STAT_CONFIGURED = 0;
    localparam int          STAT_SUSPEND    = 1;
    localparam int          STAT_TX_LED     = 2;
    localparam int          STAT_RX_LED     = 3;
    localparam int          STAT_DRV_EN     = 4;

    localparam int          OPT_W           = 4;

    typedef enum logic [3:0] {
        OPT_INPUT_PULLED_HIGH = 4'h0,
        OPT_LINE_DRIVER_EN    = 4'h1,
        OPT_POWER_ENABLE_N    = 4'h2,
        OPT_TX_LED_N          = 4'h3,
        OPT_RX_LED_N          = 4'h4,
        OPT_COMBINED_LED_N    = 4'h5,
        OPT_SUSPEND_N         = 4'h6,
        OPT_CLOCK_FAST        = 4'h7,
        OPT_CLOCK_MID         = 4'h8,
        OPT_CLOCK_SLOW        = 4'h9,
        OPT_DRIVE_HIGH        = 4'ha,
        OPT_DRIVE_LOW         = 4'hb,
        OPT_BITBANG           = 4'hc,
        OPT_INPUT_PULLED_LOW  = 4'hd
    } pin_option_t;

    // pins on which each class of option exists, bit i = aux pin i
    localparam logic [9:0]  GENERAL_PINS    = 10'h37f;
    localparam logic [9:0]  CLOCK_PINS      = 10'h361;
    localparam logic [9:0]  BITBANG_PINS    = 10'h360;
    localparam int          RESTRICTED_PIN  = 7;

    // reset values: pulled-up inputs, pin 7 pulled down
    localparam logic [31:0] CFG_LO_RESET    = 32'hd000_0000;
    localparam logic [7:0]  CFG_HI_RESET    = 8'h00;

    typedef struct packed {
        logic out;
        logic oe;
        logic pull_up;
        logic pull_down;
    } pin_drive_t;

endpackage

// *** aux_pin_function_select_monitor.sv ***
// checker for the aux pin selector: pin option behaviour and apb error replies
// assumes binding to the selector; cfg shadow follows apb writes to offset 0
`timescale 1ns/1ps
module aux_pin_function_select_monitor (
    input wire logic                          clk_sys,
    input wire logic                          rst,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [7:0]                    paddr,
    input wire logic [31:0]                   pwdata,
    input wire logic                          pready,
    input wire logic                          pslverr,
    input wire logic                          tx_start_pending,
    input wire logic                          tx_frame_active,
    input wire logic                          rx_frame_active,
    input wire logic                          usb_configured,
    input wire logic                          usb_suspend,
    input wire logic                          clk_fast_src,
    input wire aux_pin_pkg::pin_drive_t [9:0] aux_pin_bank
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [31:0] cfg_reg;
    always_ff @(posedge clk_sys or posedge rst)
        if (rst) cfg_reg <= aux_pin_pkg::CFG_LO_RESET;
        else if (psel && penable && pwrite && paddr == 8'h00) cfg_reg <= pwdata;
    wire [3:0] c0 = cfg_reg[3:0];
    wire [3:0] c1 = cfg_reg[7:4];
    wire aux_pin_pkg::pin_drive_t p0 = aux_pin_bank[0];
    sequence s_led_cause;
        $past(tx_frame_active) || $past(rx_frame_active);
    endsequence
    property p_reset_pulls;
        disable iff (1'b0) rst |-> !p0.oe && p0.pull_up && aux_pin_bank[7].pull_down;
    endproperty
    property p_drv_en;
        c0 == 4'h1 |-> p0.oe && p0.out == $past(tx_start_pending || tx_frame_active);
    endproperty
    property p_power;
        c0 == 4'h2 |-> p0.oe && p0.out == $past(!usb_configured || usb_suspend);
    endproperty
    property p_tx_led;
        c0 == 4'h3 && $past(tx_frame_active) |-> p0.oe && !p0.out;
    endproperty
    property p_rx_led;
        c0 == 4'h4 && $past(rx_frame_active) |-> p0.oe && !p0.out;
    endproperty
    property p_both_led;
        c0 == 4'h5 ##0 s_led_cause |-> p0.oe && !p0.out;
    endproperty
    property p_sleep;
        c0 == 4'h6 |-> p0.oe && p0.out == $past(!usb_suspend);
    endproperty
    property p_clock;
        c0 == 4'h7 |-> p0.oe && p0.out == (clk_fast_src && !usb_suspend);
    endproperty
    property p_pin7_input;
        !aux_pin_bank[7].oe;
    endproperty
    property p_restricted;
        c1 inside {4'h7, 4'ha, 4'hc} |-> !aux_pin_bank[1].oe && aux_pin_bank[1].pull_up;
    endproperty
    property p_unmapped;
        psel && penable |-> pready && pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0);
    endproperty
    a_reset_pulls: assert property (p_reset_pulls) else $error("reset pulls wrong");
    a_drv_en: assert property (p_drv_en) else $error("driver enable wrong");
    a_power: assert property (p_power) else $error("power enable wrong");
    a_tx_led: assert property (p_tx_led) else $error("tx led not low");
    a_rx_led: assert property (p_rx_led) else $error("rx led not low");
    a_both_led: assert property (p_both_led) else $error("combined led not low");
    a_sleep: assert property (p_sleep) else $error("suspend output wrong");
    a_clock: assert property (p_clock) else $error("clock output wrong");
    a_pin7_input: assert property (p_pin7_input) else $error("pin 7 driven");
    a_restricted: assert property (p_restricted) else $error("pin 1 option leak");
    a_unmapped: assert property (p_unmapped) else $error("apb error reply wrong");
endmodule // aux_pin_function_select_monitor

bind aux_pin_function_select aux_pin_function_select_monitor
    aux_pin_function_select_monitor_inst (.*);

// *** aux_pin_load.sv ***
// far-side load: selector drivers, pulls and floating lines per aux pin
// assumes pin levels are fed back to the selector's pin_in
`timescale 1ns/1ps
module aux_pin_load (
    input wire logic                          clk_sys,
    input wire aux_pin_pkg::pin_drive_t [9:0] aux_pin_bank,
    output logic [9:0]                        pin_level
);
    logic float_reg = 1'b0;
    // an undriven, unpulled line wanders every cycle
    always_ff @(posedge clk_sys) float_reg <= !float_reg;
    always_comb
        for (int i = 0; i < 10; i++)
            pin_level[i] = aux_pin_bank[i].oe ? aux_pin_bank[i].out :
                aux_pin_bank[i].pull_up ? 1'b1 : aux_pin_bank[i].pull_down ? 1'b0 : float_reg;
endmodule // aux_pin_load

// *** tb_aux_pin_function_select.sv ***
// self-checking bench: apb config, every option on every pin, led stretch
// assumes the far-side load model closes the pin loop
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin failures++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module tb_aux_pin_function_select;
    localparam int LS = 8;
    logic                          clk_sys;
    logic                          rst, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]                    paddr, stim;
    logic [31:0]                   pwdata, prdata, q;
    logic [9:0]                    pin_level, bb_out, bb_dir;
    logic [15:0]                   r;
    wire                           tx_start_pending, tx_frame_active, rx_frame_active;
    wire                           usb_configured, usb_suspend;
    wire                           clk_fast_src, clk_mid_src, clk_slow_src;
    aux_pin_pkg::pin_drive_t [9:0] aux_pin_bank;
    int                            failures = 0, cmp_count = 0, cycles = 0;
    assign {clk_slow_src, clk_mid_src, clk_fast_src, usb_suspend, usb_configured,
            rx_frame_active, tx_frame_active, tx_start_pending} = stim;
    aux_pin_function_select #(.LED_STRETCH(LS)) aux_pin_function_select_inst (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_start_pending(tx_start_pending), .tx_frame_active(tx_frame_active),
        .rx_frame_active(rx_frame_active), .usb_configured(usb_configured),
        .usb_suspend(usb_suspend), .clk_fast_src(clk_fast_src), .clk_mid_src(clk_mid_src),
        .clk_slow_src(clk_slow_src), .pin_in(pin_level), .aux_pin_bank(aux_pin_bank));
    aux_pin_load aux_pin_load_inst (
        .clk_sys(clk_sys), .aux_pin_bank(aux_pin_bank), .pin_level(pin_level));
    function automatic logic [15:0] lfsr(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // {oe, out}, out standing for the pull level when undriven
    function automatic logic [1:0] exp_pin(int p, logic [3:0] c, logic [7:0] s);
        logic k;
        k = aux_pin_pkg::CLOCK_PINS[p];
        if (p == 7) return (c == 4'hd) ? 2'b00 : 2'b01;
        case (c)
            4'h1: return {1'b1, s[0] | s[1]};
            4'h2: return {1'b1, !s[3] | s[4]};
            4'h3: return {1'b1, !s[1]};
            4'h4: return {1'b1, !s[2]};
            4'h5: return {1'b1, !(s[1] | s[2])};
            4'h6: return {1'b1, !s[4]};
            4'h7, 4'h8, 4'h9: return k ? {1'b1, s[c - 4'h2] & !s[4]} : 2'b01;
            4'ha: return k ? 2'b11 : 2'b01;
            4'hb: return 2'b10;
            4'hc: return aux_pin_pkg::BITBANG_PINS[p] && bb_dir[p] ? {1'b1, bb_out[p]} : 2'b01;
            default: return 2'b01;
        endcase
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk_pins(input logic [3:0] c, input logic [7:0] s);
        logic [1:0] x;
        for (int p = 0; p < 10; p++) begin
            x = exp_pin(p, c, s);
            if (!(c inside {4'h3, 4'h4, 4'h5} && x[0]))
                `CHK("pin", x, {aux_pin_bank[p].oe, aux_pin_bank[p].oe ? aux_pin_bank[p].out :
                    aux_pin_bank[p].pull_up})
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, stim} = '0;
        rst = 1'b0;
        r = 16'he3dc;
        // clean reset edge before the first clock edge
        #5;
        rst = 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, 8'h00, 32'h0);
        `CHK("cfg_lo", aux_pin_pkg::CFG_LO_RESET, q)
        apb(1'b0, 8'h04, 32'h0);
        `CHK("cfg_hi", 32'h0, q)
        for (int p = 0; p < 10; p++)
            `CHK("idle pin", {1'b0, p != 7, p == 7}, aux_pin_bank[p][2:0])
        apb(1'b0, 8'h18, 32'h0);
        `CHK("unmapped", 1'b1, e)
        $display("test reset done");
        for (int c = 0; c < 14; c++) begin
            r = lfsr(r);
            bb_out = r[9:0];
            bb_dir = r[15:6];
            apb(1'b1, 8'h00, {8{c[3:0]}});
            apb(1'b1, 8'h04, {24'h0, c[3:0], c[3:0]});
            apb(1'b1, 8'h08, {22'h0, bb_out});
            apb(1'b1, 8'h0c, {22'h0, bb_dir});
            repeat (6) begin
                r = lfsr(r);
                @(posedge clk_sys);
                stim <= r[7:0];
                repeat (2) @(posedge clk_sys);
                #1;
                chk_pins(c[3:0], r[7:0]);
            end
        end
        $display("test options done");
        apb(1'b1, 8'h00, 32'hbbbb_bbbb);
        apb(1'b1, 8'h04, 32'h0000_00bb);
        repeat (5) @(posedge clk_sys);
        apb(1'b0, 8'h10, 32'h0);
        `CHK("pin_in", 32'h0000_0080, q)
        apb(1'b1, 8'h00, 32'h3333_3333);
        stim <= 8'h19;
        repeat (LS + 4) @(posedge clk_sys);
        apb(1'b0, 8'h14, 32'h0);
        `CHK("status", 32'h0000_0013, q)
        stim <= 8'h02;
        @(posedge clk_sys);
        stim <= 8'h00;
        repeat (LS) @(posedge clk_sys);
        #1;
        `CHK("led stretched", 1'b0, aux_pin_bank[0].out)
        @(posedge clk_sys);
        #1;
        `CHK("led released", 1'b1, aux_pin_bank[0].out)
        $display("test led done");
        complete_run();
    end
endmodule // tb_aux_pin_function_select
